// >>> rtl/prif_pkg.sv
// Shared constants for the peripheral register front end
package prif_pkg;
  // Bus and window geometry
  localparam int PRIF_DATA_W = 32;
  localparam int PRIF_PORTS = 2;
  localparam int PRIF_CHANS = 4;
  localparam int PRIF_WIN_BIT = 14;
  localparam int PRIF_WIN_HI = 31;
  localparam int PRIF_WIN_LO = 15;
  localparam logic [31:0] PRIF_BASE_ADDR = 32'h0001_0000;
  // Register offsets inside one port window
  localparam logic [13:0] PRIF_OFF_CTRL = 14'h0000;
  localparam logic [13:0] PRIF_OFF_MODE = 14'h0004;
  localparam logic [13:0] PRIF_OFF_IEN = 14'h0008;
  localparam logic [13:0] PRIF_OFF_IDIS = 14'h000c;
  localparam logic [13:0] PRIF_OFF_IMASK = 14'h0010;
  localparam logic [13:0] PRIF_OFF_STAT = 14'h0014;
  localparam logic [13:0] PRIF_OFF_CHEN = 14'h0018;
  localparam logic [13:0] PRIF_OFF_CHDIS = 14'h001c;
  localparam logic [13:0] PRIF_OFF_CHSTAT = 14'h0020;
  localparam logic [13:0] PRIF_OFF_RXPTR = 14'h0030;
  localparam logic [13:0] PRIF_OFF_RXCNT = 14'h0034;
  localparam logic [13:0] PRIF_OFF_TXPTR = 14'h0038;
  localparam logic [13:0] PRIF_OFF_TXCNT = 14'h003c;
  // Control command bits
  localparam int PRIF_CTRL_RXRST = 0;
  localparam int PRIF_CTRL_TXRST = 1;
  localparam int PRIF_CTRL_STRST = 2;
  // Status bits: 0 end of receive, 1 end of transmit, 2 rx data waiting, 3 tx empty
  localparam int PRIF_STAT_W = 4;
  localparam int PRIF_MODE_W = 2;
  localparam logic [1:0] PRIF_MODE_RESET = 2'h0;
  localparam logic [1:0] PRIF_SIZE_HALF = 2'h1;
  // Transfer channel geometry
  localparam int PRIF_CNT_W = 16;
  localparam int PRIF_CHAR_W = 8;
  localparam int PRIF_FIFO_DEPTH = 16;
endpackage

// >>> rtl/prif_fifo.sv
// Parameterised synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module prif_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic flush,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [CW-1:0] count;
    logic full;
    logic empty;
  } prif_fifo_state_type;
  prif_fifo_state_type s_q, s_d;
  logic push;
  logic pop;

  always_comb begin
    s_d = s_q;
    push = inValid & ~s_q.full;
    pop = outReady & ~s_q.empty;
    if (flush) begin
      s_d.wrPtr = '0;
      s_d.rdPtr = '0;
      s_d.count = '0;
    end else begin
      if (push) begin
        s_d.mem[s_q.wrPtr] = inData;
        s_d.wrPtr = AW'(s_q.wrPtr + 1'b1);
      end
      if (pop) begin
        s_d.rdPtr = AW'(s_q.rdPtr + 1'b1);
      end
      s_d.count = CW'(s_q.count + CW'(push) - CW'(pop));
    end
    s_d.full = (s_d.count == CW'(DEPTH));
    s_d.empty = (s_d.count == '0);
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_q <= '{default: '0, empty: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  assign inReady = ~s_q.full;
  assign outValid = ~s_q.empty;
  assign outData = s_q.mem[s_q.rdPtr];
endmodule // prif_fifo
`default_nettype wire

// >>> rtl/prif_xfer_channel.sv
// One transfer channel: memory address pointer and transfer count
`timescale 1ns/1ps
`default_nettype none
module prif_xfer_channel
  import prif_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic loadPtr,
  input wire logic loadCnt,
  input wire logic [31:0] wrData,
  input wire logic step,
  input wire logic [2:0] stepSize,
  output logic [31:0] ptr,
  output logic [PRIF_CNT_W-1:0] cnt
);
  typedef struct packed {
    logic [31:0] ptr;
    logic [PRIF_CNT_W-1:0] cnt;
  } prif_chan_state_type;
  prif_chan_state_type s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (step) begin
      s_d.ptr = s_q.ptr + {29'h0, stepSize}; // [R17]
      s_d.cnt = s_q.cnt - 16'h0001; // [R17]
    end
    if (loadPtr) begin
      s_d.ptr = wrData;
    end
    if (loadCnt) begin
      s_d.cnt = wrData[PRIF_CNT_W-1:0]; // [R15]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ptr = s_q.ptr;
  assign cnt = s_q.cnt;
endmodule // prif_xfer_channel
`default_nettype wire

// >>> rtl/prif_regs.sv
// Peripheral register front end for two serial ports with four transfer channels
//
// How it works
// R1: The register slave sits on a 32-bit wide peripheral bus.
// R2: Only word accesses exist, so the two low address bits are ignored.
// R3: Each serial port decodes a 16-Kbyte window; the interrupt controller's 4-Kbyte window is elsewhere.
// R4: The control register is write-only and a one launches a command while a zero does nothing.
// R5: The mode register is read/write configuration and clears to zero on reset.
// R6: The status register is read-only and writes to it change nothing.
// R7: A one written to a channel enable register sets the matching channel status bit.
// R8: A one written to a channel disable register clears the matching status bit, visible on read.
// R9: Zeros written to enable or disable registers leave the status bits alone.
// R10: Unused bits read as zero and software writes zero into them.
// R11: The interrupt output is the OR of every status bit ANDed with its mask bit.
// R12: The mask is readable, set by ones to the interrupt enable and cleared by the interrupt disable.
// R13: There are four transfer channels, one per receiver and one per transmitter of the two ports.
// R14: Each channel's registers lie inside its own serial port window.
// R15: Each channel holds a 32-bit address pointer and a 16-bit transfer count.
// R16: When the count runs out an end-of-transfer status flag is set and may interrupt.
// R17: Each completed transfer advances the pointer by the transfer size and decrements the count.
`timescale 1ns/1ps
`default_nettype none
module prif_regs
  import prif_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  // Peripheral bus slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [PRIF_DATA_W-1:0] pwdata,
  output logic [PRIF_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt sources, one per port
  output logic [PRIF_PORTS-1:0] irq,
  // Received characters from each serial receiver
  input wire logic [PRIF_PORTS-1:0] rxValid,
  input wire logic [PRIF_PORTS-1:0][PRIF_CHAR_W-1:0] rxData,
  output logic [PRIF_PORTS-1:0] rxReady,
  // Characters for each serial transmitter
  output logic [PRIF_PORTS-1:0] txValid,
  output logic [PRIF_PORTS-1:0][PRIF_CHAR_W-1:0] txData,
  input wire logic [PRIF_PORTS-1:0] txReady,
  // Receive channel memory writes
  output logic [PRIF_PORTS-1:0] rxMemReq,
  output logic [PRIF_PORTS-1:0][31:0] rxMemAddr,
  output logic [PRIF_PORTS-1:0][31:0] rxMemData,
  input wire logic [PRIF_PORTS-1:0] rxMemAck,
  // Transmit channel memory reads
  output logic [PRIF_PORTS-1:0] txMemReq,
  output logic [PRIF_PORTS-1:0][31:0] txMemAddr,
  input wire logic [PRIF_PORTS-1:0][PRIF_CHAR_W-1:0] txMemData,
  input wire logic [PRIF_PORTS-1:0] txMemAck
);
  typedef struct packed {
    logic [PRIF_MODE_W-1:0] mode;
    logic [1:0] chanEn;
    logic [1:0] endFlag;
    logic [PRIF_STAT_W-1:0] mask;
    logic rxReq;
    logic txReq;
    logic [31:0] rxAddr;
    logic [31:0] rxWord;
    logic [31:0] txAddr;
    logic txFull;
    logic [PRIF_CHAR_W-1:0] txChar;
    logic irq;
  } prif_port_type;

  typedef struct packed {
    prif_port_type [PRIF_PORTS-1:0] port;
    logic [PRIF_DATA_W-1:0] rdata;
    logic ready;
    logic slvErr;
  } prif_state_type;

  prif_state_type s_q, s_d;

  logic [PRIF_CHANS-1:0] chLoadPtr;
  logic [PRIF_CHANS-1:0] chLoadCnt;
  logic [PRIF_CHANS-1:0] chStep;
  logic [PRIF_CHANS-1:0][31:0] chPtr;
  logic [PRIF_CHANS-1:0][PRIF_CNT_W-1:0] chCnt;
  logic [PRIF_PORTS-1:0] fifoPop;
  logic [PRIF_PORTS-1:0] fifoFlush;
  logic [PRIF_PORTS-1:0] fifoValid;
  logic [PRIF_PORTS-1:0][PRIF_CHAR_W-1:0] fifoData;
  logic hit;
  logic setup;
  logic wrEn;
  logic portSel;
  logic [13:0] off;
  logic [1:0] rxIdx;
  logic [1:0] txIdx;

  // Bytes moved per transfer for a mode setting
  function automatic logic [2:0] stepOf(input logic [PRIF_MODE_W-1:0] mode);
    logic [2:0] size;
    size = 3'h4;
    if (mode == PRIF_MODE_RESET) begin
      size = 3'h1;
    end else if (mode == PRIF_SIZE_HALF) begin
      size = 3'h2;
    end
    return size;
  endfunction

  // Live status word of one port
  function automatic logic [PRIF_STAT_W-1:0] statOf(input prif_port_type pt,
                                                    input logic avail);
    return {~pt.txFull, avail, pt.endFlag};
  endfunction

  always_comb begin
    s_d = s_q;
    chLoadPtr = '0;
    chLoadCnt = '0;
    chStep = '0;
    fifoPop = '0;
    fifoFlush = '0;
    rxIdx = '0;
    txIdx = '0;
    hit = (paddr[PRIF_WIN_HI:PRIF_WIN_LO] == PRIF_BASE_ADDR[PRIF_WIN_HI:PRIF_WIN_LO]); // [R3]
    portSel = paddr[PRIF_WIN_BIT]; // [R3]
    off = {paddr[13:2], 2'b00}; // [R2]
    setup = psel & ~penable;
    wrEn = psel & penable & s_q.ready & pwrite & hit;
    rxIdx = {portSel, 1'b0};
    txIdx = {portSel, 1'b1};

    // Setup phase loads the answer; access phase sees ready [R1]
    s_d.ready = setup;
    if (setup) begin
      s_d.slvErr = 1'b0;
      s_d.rdata = '0; // [R10]
      unique case (off)
        PRIF_OFF_CTRL, PRIF_OFF_IEN, PRIF_OFF_IDIS, PRIF_OFF_CHEN, PRIF_OFF_CHDIS: begin
          s_d.rdata = '0; // [R4]
        end
        PRIF_OFF_MODE: begin
          s_d.rdata[PRIF_MODE_W-1:0] = s_q.port[portSel].mode; // [R5]
        end
        PRIF_OFF_IMASK: begin
          s_d.rdata[PRIF_STAT_W-1:0] = s_q.port[portSel].mask; // [R12]
        end
        PRIF_OFF_STAT: begin
          s_d.rdata[PRIF_STAT_W-1:0] = statOf(s_q.port[portSel], fifoValid[portSel]); // [R6]
        end
        PRIF_OFF_CHSTAT: begin
          s_d.rdata[1:0] = s_q.port[portSel].chanEn; // [R8]
        end
        PRIF_OFF_RXPTR: begin
          s_d.rdata = chPtr[rxIdx]; // [R14]
        end
        PRIF_OFF_RXCNT: begin
          s_d.rdata[PRIF_CNT_W-1:0] = chCnt[rxIdx]; // [R14]
        end
        PRIF_OFF_TXPTR: begin
          s_d.rdata = chPtr[txIdx]; // [R14]
        end
        PRIF_OFF_TXCNT: begin
          s_d.rdata[PRIF_CNT_W-1:0] = chCnt[txIdx]; // [R14]
        end
        default: begin
          s_d.slvErr = 1'b1;
        end
      endcase
      if (!hit) begin
        s_d.slvErr = 1'b1;
      end
    end

    for (int p = 0; p < PRIF_PORTS; p++) begin
      // Register writes to this port's window
      if (wrEn && (int'(portSel) == p)) begin
        unique case (off)
          PRIF_OFF_CTRL: begin
            if (pwdata[PRIF_CTRL_RXRST]) begin // [R4]
              s_d.port[p].chanEn[0] = 1'b0;
              fifoFlush[p] = 1'b1;
            end
            if (pwdata[PRIF_CTRL_TXRST]) begin // [R4]
              s_d.port[p].chanEn[1] = 1'b0;
              s_d.port[p].txFull = 1'b0;
            end
            if (pwdata[PRIF_CTRL_STRST]) begin // [R4]
              s_d.port[p].endFlag = '0;
            end
          end
          PRIF_OFF_MODE: begin
            s_d.port[p].mode = pwdata[PRIF_MODE_W-1:0]; // [R5]
          end
          PRIF_OFF_IEN: begin
            s_d.port[p].mask = s_q.port[p].mask | pwdata[PRIF_STAT_W-1:0]; // [R12]
          end
          PRIF_OFF_IDIS: begin
            s_d.port[p].mask = s_q.port[p].mask & ~pwdata[PRIF_STAT_W-1:0]; // [R12]
          end
          PRIF_OFF_CHEN: begin
            s_d.port[p].chanEn = s_q.port[p].chanEn | pwdata[1:0]; // [R7] [R9]
          end
          PRIF_OFF_CHDIS: begin
            s_d.port[p].chanEn = s_q.port[p].chanEn & ~pwdata[1:0]; // [R8] [R9]
          end
          PRIF_OFF_RXPTR, PRIF_OFF_RXCNT: begin
            chLoadPtr[2*p] = (off == PRIF_OFF_RXPTR); // [R14]
            chLoadCnt[2*p] = (off == PRIF_OFF_RXCNT); // [R14]
          end
          PRIF_OFF_TXPTR, PRIF_OFF_TXCNT: begin
            chLoadPtr[2*p+1] = (off == PRIF_OFF_TXPTR); // [R14]
            chLoadCnt[2*p+1] = (off == PRIF_OFF_TXCNT); // [R14]
          end
          default: begin
            // Status, read-only and unmapped offsets keep all state [R6]
          end
        endcase
      end

      // Transmitter takes the held character
      if (s_q.port[p].txFull && txReady[p]) begin
        s_d.port[p].txFull = 1'b0;
      end

      // Receive channel: one FIFO character per memory write [R13]
      if (s_q.port[p].rxReq) begin
        if (rxMemAck[p]) begin
          s_d.port[p].rxReq = 1'b0;
          chStep[2*p] = 1'b1; // [R17]
          fifoPop[p] = 1'b1;
          if (chCnt[2*p] == 16'h0001) begin
            s_d.port[p].endFlag[0] = 1'b1; // [R16]
          end
        end
      end else if (s_q.port[p].chanEn[0] && chCnt[2*p] != '0 && fifoValid[p]) begin // [R17]
        s_d.port[p].rxReq = 1'b1;
        s_d.port[p].rxAddr = chPtr[2*p];
        s_d.port[p].rxWord = {24'h0, fifoData[p]};
      end

      // Transmit channel: one memory read per character [R13]
      if (s_q.port[p].txReq) begin
        if (txMemAck[p]) begin
          s_d.port[p].txReq = 1'b0;
          s_d.port[p].txFull = 1'b1;
          s_d.port[p].txChar = txMemData[p];
          chStep[2*p+1] = 1'b1; // [R17]
          if (chCnt[2*p+1] == 16'h0001) begin
            s_d.port[p].endFlag[1] = 1'b1; // [R16]
          end
        end
      end else if (s_q.port[p].chanEn[1] && chCnt[2*p+1] != '0 && !s_q.port[p].txFull) begin // [R17]
        s_d.port[p].txReq = 1'b1;
        s_d.port[p].txAddr = chPtr[2*p+1];
      end

      // Masked status ORed into the interrupt source [R11] [R16]
      s_d.port[p].irq = |(statOf(s_q.port[p], fifoValid[p]) & s_q.port[p].mask);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_q <= '0; // [R5]
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.rdata;
  assign pready = s_q.ready;
  assign pslverr = s_q.slvErr;

  for (genvar g = 0; g < PRIF_PORTS; g++) begin : gPort
    assign irq[g] = s_q.port[g].irq;
    assign txValid[g] = s_q.port[g].txFull;
    assign txData[g] = s_q.port[g].txChar;
    assign rxMemReq[g] = s_q.port[g].rxReq;
    assign rxMemAddr[g] = s_q.port[g].rxAddr;
    assign rxMemData[g] = s_q.port[g].rxWord;
    assign txMemReq[g] = s_q.port[g].txReq;
    assign txMemAddr[g] = s_q.port[g].txAddr;

    prif_fifo #(
      .WIDTH(PRIF_CHAR_W),
      .DEPTH(PRIF_FIFO_DEPTH)
    ) uRxFifo (
      .clk_sys(clk_sys),
      .reset(reset),
      .flush(fifoFlush[g]),
      .inValid(rxValid[g]),
      .inReady(rxReady[g]),
      .inData(rxData[g]),
      .outValid(fifoValid[g]),
      .outReady(fifoPop[g]),
      .outData(fifoData[g])
    );

    for (genvar d = 0; d < 2; d++) begin : gChan
      prif_xfer_channel uChan (
        .clk_sys(clk_sys),
        .reset(reset),
        .loadPtr(chLoadPtr[2*g+d]),
        .loadCnt(chLoadCnt[2*g+d]),
        .wrData(pwdata),
        .step(chStep[2*g+d]),
        .stepSize(stepOf(s_q.port[g].mode)),
        .ptr(chPtr[2*g+d]),
        .cnt(chCnt[2*g+d])
      );
    end
  end
endmodule // prif_regs
`default_nettype wire

// >>> sim/prif_regs_props.sv
// Port-level checks on the register front end
`timescale 1ns/1ps
`default_nettype none
module prif_regs_props
  import prif_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic [PRIF_PORTS-1:0] irq,
  input wire logic [PRIF_PORTS-1:0] rxMemReq,
  input wire logic [PRIF_PORTS-1:0][31:0] rxMemAddr,
  input wire logic [PRIF_PORTS-1:0][31:0] rxMemData,
  input wire logic [PRIF_PORTS-1:0] rxMemAck,
  input wire logic [PRIF_PORTS-1:0] txMemReq,
  input wire logic [PRIF_PORTS-1:0][PRIF_CHAR_W-1:0] txMemData,
  input wire logic [PRIF_PORTS-1:0] txMemAck,
  input wire logic [PRIF_PORTS-1:0] txValid,
  input wire logic [PRIF_PORTS-1:0][PRIF_CHAR_W-1:0] txData,
  input wire logic [PRIF_PORTS-1:0] txReady
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  property p_answer; psel && !penable |=> pready; endproperty
  property p_pulse; pready |=> !pready; endproperty
  property p_idle; !psel |=> !pready; endproperty
  property p_rx_hold; rxMemReq[0] && !rxMemAck[0] |=> rxMemReq[0] && $stable(rxMemAddr[0]);
  endproperty
  property p_rx_drop; rxMemReq[1] && rxMemAck[1] |=> !rxMemReq[1]; endproperty
  property p_rx_zext; rxMemReq[0] |-> rxMemData[0][31:8] == 24'h0; endproperty
  property p_tx_load;
    txMemReq[1] && txMemAck[1] |=> txValid[1] && txData[1] == $past(txMemData[1]);
  endproperty
  property p_tx_hold; txValid[1] && !txReady[1] |=> txValid[1] && $stable(txData[1]); endproperty
  property p_tx_one; txValid[1] |-> !txMemReq[1]; endproperty
  a_answer: assert property (p_answer) else $error("no answer after setup");
  a_pulse: assert property (p_pulse) else $error("answer longer than one cycle");
  a_idle: assert property (p_idle) else $error("answer without setup");
  a_rx_hold: assert property (p_rx_hold) else $error("rx request not held");
  a_rx_drop: assert property (p_rx_drop) else $error("rx request kept after ack");
  a_rx_zext: assert property (p_rx_zext) else $error("rx data upper bits set");
  a_tx_load: assert property (p_tx_load) else $error("tx char not loaded");
  a_tx_hold: assert property (p_tx_hold) else $error("tx char not held");
  a_tx_one: assert property (p_tx_one) else $error("tx request while char held");
  c_rx: cover property (rxMemReq[0] && rxMemAck[0]);
  c_tx: cover property (txMemReq[1] && txMemAck[1]);
  c_irq: cover property ($rose(irq[0]));
endmodule // prif_regs_props
bind prif_regs prif_regs_props chk_u (.clk_sys, .reset, .psel, .penable, .pready, .irq,
  .rxMemReq, .rxMemAddr, .rxMemData, .rxMemAck, .txMemReq, .txMemData, .txMemAck,
  .txValid, .txData, .txReady);
`default_nettype wire

// >>> sim/prif_mem_model.sv
// Memory and transmitter partner for the transfer channels
`timescale 1ns/1ps
`default_nettype none
module prif_mem_model
  import prif_pkg::*;
#(
  parameter int DLY = 2
) (
  input wire logic clk_sys,
  input wire logic stall,
  input wire logic [PRIF_PORTS-1:0] rxMemReq,
  input wire logic [PRIF_PORTS-1:0] txMemReq,
  input wire logic [PRIF_PORTS-1:0][31:0] txMemAddr,
  output logic [PRIF_PORTS-1:0] rxMemAck,
  output logic [PRIF_PORTS-1:0] txMemAck,
  output logic [PRIF_PORTS-1:0][PRIF_CHAR_W-1:0] txMemData,
  output logic [PRIF_PORTS-1:0] txReady
);
  int rxWait[PRIF_PORTS] = '{default: 0};
  int txWait[PRIF_PORTS] = '{default: 0};
  initial begin
    {rxMemAck, txMemAck, txMemData, txReady} = '0;
  end
  // Slow memory: acknowledge after DLY cycles; read data toggles outside the ack
  always @(negedge clk_sys) begin
    for (int p = 0; p < PRIF_PORTS; p++) begin
      rxMemAck[p] <= rxMemReq[p] && !rxMemAck[p] && rxWait[p] >= DLY;
      rxWait[p] <= (rxMemReq[p] && !rxMemAck[p]) ? rxWait[p] + 1 : 0;
      txMemAck[p] <= txMemReq[p] && !txMemAck[p] && txWait[p] >= DLY;
      txWait[p] <= (txMemReq[p] && !txMemAck[p]) ? txWait[p] + 1 : 0;
      txMemData[p] <= (txMemReq[p] && !txMemAck[p] && txWait[p] >= DLY) ?
                      txMemAddr[p][7:0] : ~txMemData[p];
      txReady[p] <= !stall;
    end
  end
endmodule // prif_mem_model
`default_nettype wire

// >>> sim/test_prif_regs.sv
// Self-checking bench for the register front end
`timescale 1ns/1ps
`default_nettype none
module test_prif_regs
  import prif_pkg::*;
;
  logic clk_sys, reset, psel, penable, pwrite, pready, pslverr, stall, err;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [PRIF_PORTS-1:0] irq, rxValid, rxReady, txValid, txReady;
  logic [PRIF_PORTS-1:0] rxMemReq, rxMemAck, txMemReq, txMemAck;
  logic [PRIF_PORTS-1:0][PRIF_CHAR_W-1:0] rxData, txData, txMemData;
  logic [PRIF_PORTS-1:0][31:0] rxMemAddr, rxMemData, txMemAddr;
  int n_mismatch = 0;
  int check_count = 0;
  logic [31:0] rxSeenAddr, rxSeenData;
  always @(posedge clk_sys) begin
    if (rxMemReq[0] && rxMemAck[0]) begin
      rxSeenAddr <= rxMemAddr[0];
      rxSeenData <= rxMemData[0];
    end
  end
  prif_regs dut_u (.clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq, .rxValid, .rxData, .rxReady, .txValid, .txData, .txReady,
    .rxMemReq, .rxMemAddr, .rxMemData, .rxMemAck, .txMemReq, .txMemAddr, .txMemData,
    .txMemAck);
  prif_mem_model #(.DLY(3)) mem_u (.clk_sys, .stall, .rxMemReq, .txMemReq, .txMemAddr,
    .rxMemAck, .txMemAck, .txMemData, .txReady);
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic w, input int p, input logic [13:0] off, input logic [31:0] d);
    @(negedge clk_sys);
    psel = 1'b1;
    pwrite = w;
    pwdata = d;
    paddr = PRIF_BASE_ADDR | (32'(p) << PRIF_WIN_BIT) | 32'(off);
    @(negedge clk_sys);
    penable = 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    @(negedge clk_sys);
    {psel, penable} = 2'b00;
    pwdata = ~d;
  endtask
  task automatic wr(input int p, input logic [13:0] off, input logic [31:0] d);
    acc(1'b1, p, off, d);
  endtask
  task automatic rdx(input int p, input logic [13:0] off, input logic [31:0] x);
    acc(1'b0, p, off, 32'h0);
    chk(rd, x);
  endtask
  task automatic wait_stat(input int p, input logic [31:0] m);
    rd = 32'h0;
    for (int i = 0; i < 200 && (rd & m) !== m; i++) acc(1'b0, p, PRIF_OFF_STAT, 32'h0);
  endtask
  task automatic push(input int p, input logic [7:0] d);
    @(negedge clk_sys);
    rxValid[p] = 1'b1;
    rxData[p] = d;
    for (int i = 0; i < 50; i++) begin
      @(posedge clk_sys);
      if (rxReady[p] === 1'b1) break;
    end
    @(negedge clk_sys);
    rxValid[p] = 1'b0;
    rxData[p] = ~d;
  endtask
  task automatic t_regs;
    rdx(0, PRIF_OFF_MODE, 32'h0);
    chk(32'(err), 32'h0);
    rdx(0, PRIF_OFF_STAT, 32'h8);
    rdx(0, PRIF_OFF_CTRL, 32'h0);
    chk(32'(irq), 32'h0);
    wr(0, PRIF_OFF_STAT, 32'hf);
    rdx(0, PRIF_OFF_STAT, 32'h8);
    wr(0, PRIF_OFF_MODE | 14'h2, 32'h1);
    rdx(0, PRIF_OFF_MODE, 32'h1);
    wr(1, PRIF_OFF_RXCNT, 32'hffff);
    rdx(1, PRIF_OFF_RXCNT, 32'hffff);
    wr(1, PRIF_OFF_TXPTR, 32'hffff_fffd);
    rdx(1, PRIF_OFF_TXPTR, 32'hffff_fffd);
    rdx(0, PRIF_OFF_TXPTR, 32'h0);
    rdx(0, 14'h0040, 32'h0);
    chk(32'(err), 32'h1);
    wr(2, PRIF_OFF_MODE, 32'h3);
    chk(32'(err), 32'h1);
    rdx(0, PRIF_OFF_MODE, 32'h1);
    $display("test regs done");
  endtask
  task automatic t_shadow;
    wr(0, PRIF_OFF_CHEN, 32'h1);
    rdx(0, PRIF_OFF_CHSTAT, 32'h1);
    wr(0, PRIF_OFF_CHEN, 32'h2);
    rdx(0, PRIF_OFF_CHSTAT, 32'h3);
    wr(0, PRIF_OFF_CHDIS, 32'h1);
    rdx(0, PRIF_OFF_CHSTAT, 32'h2);
    wr(0, PRIF_OFF_CHDIS, 32'h2);
    wr(0, PRIF_OFF_IEN, 32'h5);
    rdx(0, PRIF_OFF_IMASK, 32'h5);
    wr(0, PRIF_OFF_IDIS, 32'h4);
    rdx(0, PRIF_OFF_IMASK, 32'h1);
    $display("test shadow done");
  endtask
  task automatic t_rx;
    wr(0, PRIF_OFF_RXPTR, 32'h100);
    wr(0, PRIF_OFF_RXCNT, 32'h2);
    push(0, 8'ha1);
    push(0, 8'ha2);
    push(0, 8'ha3);
    wr(0, PRIF_OFF_CHEN, 32'h1);
    wait_stat(0, 32'h1);
    rdx(0, PRIF_OFF_RXPTR, 32'h104);
    rdx(0, PRIF_OFF_RXCNT, 32'h0);
    chk(rxSeenAddr, 32'h102);
    chk(rxSeenData, 32'ha2);
    rdx(0, PRIF_OFF_STAT, 32'hd);
    chk(32'(irq[0]), 32'h1);
    wr(0, PRIF_OFF_IDIS, 32'h1);
    repeat (2) @(negedge clk_sys);
    chk(32'(irq[0]), 32'h0);
    wr(0, PRIF_OFF_CTRL, 32'h5);
    rdx(0, PRIF_OFF_STAT, 32'h8);
    rdx(0, PRIF_OFF_CHSTAT, 32'h0);
    $display("test rx done");
  endtask
  task automatic t_tx;
    stall <= 1'b1;
    wr(1, PRIF_OFF_IEN, 32'h2);
    wr(1, PRIF_OFF_TXPTR, 32'h20);
    wr(1, PRIF_OFF_TXCNT, 32'h2);
    wr(1, PRIF_OFF_CHEN, 32'h2);
    for (int i = 0; i < 100 && txValid[1] !== 1'b1; i++) @(negedge clk_sys);
    repeat (3) @(negedge clk_sys);
    chk(32'(txValid[1]), 32'h1);
    chk(32'(txData[1]), 32'h20);
    stall <= 1'b0;
    wait_stat(1, 32'h2);
    rdx(1, PRIF_OFF_TXPTR, 32'h22);
    rdx(1, PRIF_OFF_TXCNT, 32'h0);
    chk(32'(irq[1]), 32'h1);
    wr(1, PRIF_OFF_CTRL, 32'h2);
    rdx(1, PRIF_OFF_CHSTAT, 32'h0);
    rdx(1, PRIF_OFF_STAT, 32'ha);
    $display("test tx done");
  endtask
  task automatic t_fifo;
    for (int k = 0; k < PRIF_FIFO_DEPTH; k++) push(1, 8'(k));
    chk(32'(rxReady[1]), 32'h0);
    wr(1, PRIF_OFF_MODE, 32'h2);
    wr(1, PRIF_OFF_RXPTR, 32'h200);
    wr(1, PRIF_OFF_RXCNT, 32'h10);
    wr(1, PRIF_OFF_CHEN, 32'h1);
    wait_stat(1, 32'h1);
    chk(rd & 32'h5, 32'h1);
    rdx(1, PRIF_OFF_RXPTR, 32'h240);
    chk(32'(rxReady[1]), 32'h1);
    $display("test fifo done");
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    tally_and_finish;
  end
  initial begin
    reset = 1'b1;
    {psel, penable, pwrite, stall, err} = '0;
    {paddr, pwdata, rd, rxValid, rxData} = '0;
    repeat (20) @(negedge clk_sys);
    reset = 1'b0;
    t_regs;
    t_shadow;
    t_rx;
    t_tx;
    t_fifo;
    tally_and_finish;
  end
endmodule // test_prif_regs
`default_nettype wire
